// *** src/mac_flow_regs.vh ***
// register map, field positions, reset values and timing counts
// assumes a 25 MHz register clock and a 32-bit bus
`ifndef MAC_FLOW_REGS_VH
`define MAC_FLOW_REGS_VH

`define OFS_STATUS      8'h00
`define OFS_EMU_CTRL    8'h04
`define OFS_FIFO_CTRL   8'h08
`define OFS_BUILD       8'h0C
`define OFS_IRQ_STATUS  8'h10
`define OFS_IRQ_MASK    8'h14

`define ST_TX_PAUSE     0
`define ST_RX_FLOW      1
`define ST_RX_QOS       2
`define ST_FCH_LO       8
`define ST_FCH_HI       10
`define ST_FCODE_LO     12
`define ST_FCODE_HI     15

`define EMU_FREE        0
`define EMU_SOFT        1

`define THR_LO          0
`define THR_HI          1
`define THR_RESET       2'h2

`define BUILD_TX_CELLS  8'h03
`define BUILD_RX_CELLS  8'h03
`define BUILD_ADDR_KIND 8'h01
`define BUILD_MAC_VALUE 8'h01

`define IRQ_HOST_FAULT  0
`define IRQ_PAUSE_START 1
`define IRQ_RX_FLOW     2
`define IRQ_BITS        3

`define CLK_PERIOD_NS   40
`define QUANTUM_NS      5120
`define QUANTUM_CYCLES  (`QUANTUM_NS / `CLK_PERIOD_NS)

`endif

// *** src/pause_timer.v ***
// pause-time counter for received pause frames
// assumes quanta arrive with a one-cycle load strobe
`timescale 1ns/1ps
`include "mac_flow_regs.vh"

module pause_timer #(
  parameter QW       = 16,
  parameter QCYCLES  = `QUANTUM_CYCLES
) (
  input  wire          i_clk,
  input  wire          i_rst_n,
  input  wire          i_ce,
  input  wire          i_load,
  input  wire [QW-1:0] i_quanta,
  output reg           o_active
);

  reg [QW-1:0] quanta_r;
  reg [15:0]   tick_r;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      quanta_r <= {QW{1'b0}};
      tick_r   <= 16'h0000;
      o_active <= 1'b0;
    end else if (i_ce) begin
      if (i_load) begin
        // a new pause frame restarts the count; zero quanta ends pause
        quanta_r <= i_quanta;
        tick_r   <= 16'h0000;
        o_active <= (i_quanta != {QW{1'b0}});
      end else if (o_active) begin
        if (tick_r == QCYCLES[15:0] - 16'h0001) begin
          tick_r   <= 16'h0000;
          quanta_r <= quanta_r - {{(QW-1){1'b0}}, 1'b1};
          if (quanta_r == {{(QW-1){1'b0}}, 1'b1})
            o_active <= 1'b0;
        end else begin
          tick_r <= tick_r + 16'h0001;
        end
      end
    end
  end

endmodule

// *** src/mac_flow_status.v ***
// mac flow status, emulation control, tx fifo start gating, build info
// assumes an ahb-lite master, free-buffer counts and thresholds from
// the rx dma, and a tx fifo that reports cells held per packet
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "mac_flow_regs.vh"

// Function
// [RQ1] qos flag: enabled and any count at low threshold
// [RQ2] flow flag: any count at own threshold
// [RQ3] pause flag high while pause time counts
// [RQ4] no new frame during pause, except pause frames
// [RQ5] frame in progress finishes despite pause
// [RQ6] start only after threshold cells are buffered
// [RQ7] short packet starts once wholly buffered
// [RQ8] software writes threshold 2 or 3 only
// [RQ9] tx fifo depth reads 3 in bits 31-24
// [RQ10] rx fifo depth reads 3 in bits 23-16
// [RQ11] fault channel field holds failing rx channel
// [RQ12] status read clears fault channel field
// [RQ13] fault code: 0 none, 2h ownership, 4h null
// [RQ14] reserved bits read zero, writes ignored
// [RQ15] emulation soft/free bits plain storage, reset zero
module mac_flow_status #(
  parameter NCH  = 8,
  parameter CW   = 8,
  parameter QW   = 16,
  parameter QCYC = `QUANTUM_CYCLES
) (
  input  wire              i_clk,
  input  wire              i_rst_n,
  input  wire              i_ce,
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output reg  [31:0]       hrdata,
  output reg               hreadyout,
  output reg               hresp,
  input  wire              i_rx_qos_enable,
  input  wire [CW-1:0]     i_rx_qos_low_threshold,
  input  wire [NCH*CW-1:0] i_rx_chan_free_buffers,
  input  wire [NCH*CW-1:0] i_rx_chan_flow_threshold,
  input  wire              i_rx_fault,
  input  wire [2:0]        i_rx_fault_channel,
  input  wire [3:0]        i_rx_fault_code,
  input  wire              i_pause_rx,
  input  wire [QW-1:0]     i_pause_quanta,
  input  wire              i_tx_pkt_ready,
  input  wire              i_tx_pkt_is_pause,
  input  wire [7:0]        i_tx_pkt_cells,
  input  wire              i_tx_pkt_whole,
  input  wire              i_tx_pkt_done,
  output reg               o_rx_qos_active,
  output reg               o_rx_flow_active,
  output reg               o_tx_pause_active,
  output reg               o_tx_start,
  output reg               o_tx_sending,
  output reg               o_emu_soft,
  output reg               o_emu_free,
  output reg               o_irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  ////////////////////////////////////////////////////////////////////
  // ahb-lite slave: one-cycle address phase, zero-wait data phase

  reg        wr_pend_r;
  reg [7:0]  wr_ofs_r;
  wire       addr_ok;
  wire       rd_take;
  wire [7:0] a_ofs;

  // hsize is ignored: every register is one whole word
  assign addr_ok = hsel & hready & htrans[1];
  assign rd_take = addr_ok & ~hwrite;
  assign a_ofs   = {haddr[7:2], 2'b00};

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (i_ce) begin
      wr_pend_r <= addr_ok & hwrite;
      if (addr_ok)
        wr_ofs_r <= a_ofs;
    end
  end

  wire wr_emu;
  wire wr_fifo;
  wire wr_ists;
  wire wr_imsk;
  wire rd_status;

  assign wr_emu    = wr_pend_r & (wr_ofs_r == `OFS_EMU_CTRL);
  assign wr_fifo   = wr_pend_r & (wr_ofs_r == `OFS_FIFO_CTRL);
  assign wr_ists   = wr_pend_r & (wr_ofs_r == `OFS_IRQ_STATUS);
  assign wr_imsk   = wr_pend_r & (wr_ofs_r == `OFS_IRQ_MASK);
  assign rd_status = rd_take & (a_ofs == `OFS_STATUS);

  ////////////////////////////////////////////////////////////////////
  // rx flow and qos comparisons, one per channel

  wire [NCH-1:0] low_hit;
  wire [NCH-1:0] flow_hit;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_chan
      wire [CW-1:0] fb;
      wire [CW-1:0] ft;
      assign fb = i_rx_chan_free_buffers[g*CW +: CW];
      assign ft = i_rx_chan_flow_threshold[g*CW +: CW];
      assign low_hit[g]  = (fb <= i_rx_qos_low_threshold);
      assign flow_hit[g] = (fb <= ft);
    end
  endgenerate

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rx_qos_active  <= 1'b0;
      o_rx_flow_active <= 1'b0;
    end else if (i_ce) begin
      o_rx_qos_active  <= i_rx_qos_enable & (|low_hit); // [RQ1]
      o_rx_flow_active <= |flow_hit;                    // [RQ2]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pause time from received pause frames

  // start gating reads the timer itself, a cycle ahead of the flag
  wire pause_act;

  pause_timer #(
    .QW      (QW),
    .QCYCLES (QCYC)
  ) u_pause (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_ce     (i_ce),
    .i_load   (i_pause_rx),
    .i_quanta (i_pause_quanta),
    .o_active (pause_act)
  );

  always @(posedge i_clk) begin
    if (!i_rst_n)
      o_tx_pause_active <= 1'b0;
    else if (i_ce)
      o_tx_pause_active <= pause_act; // [RQ3]
  end

  ////////////////////////////////////////////////////////////////////
  // rx host fault capture

  reg [2:0] fault_ch_r;
  reg [3:0] fault_code_r;
  reg [2:0] fault_ch_nxt;
  reg [3:0] fault_code_nxt;

  // a new fault wins over the clearing read; the code stays until the next fault or reset
  always @* begin
    fault_ch_nxt   = fault_ch_r;
    fault_code_nxt = fault_code_r;
    if (i_rx_fault) begin
      fault_ch_nxt   = i_rx_fault_channel; // [RQ11]
      fault_code_nxt = i_rx_fault_code;    // [RQ13]
    end else if (rd_status) begin
      fault_ch_nxt = 3'h0;                 // [RQ12]
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      fault_ch_r   <= 3'h0;
      fault_code_r <= 4'h0;
    end else if (i_ce) begin
      fault_ch_r   <= fault_ch_nxt;
      fault_code_r <= fault_code_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // emulation and fifo control registers

  reg [1:0] thr_r;
  reg [1:0] thr_nxt;

  always @* begin
    thr_nxt = thr_r;
    if (wr_fifo)
      thr_nxt = hwdata[`THR_HI:`THR_LO]; // [RQ14]
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_emu_soft <= 1'b0;
      o_emu_free <= 1'b0;
      thr_r      <= `THR_RESET;
    end else if (i_ce) begin
      if (wr_emu) begin
        o_emu_soft <= hwdata[`EMU_SOFT]; // [RQ15]
        o_emu_free <= hwdata[`EMU_FREE]; // [RQ15]
      end
      thr_r <= thr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transmit start gating

  reg  st_r;
  wire enough;
  wire may_go;

  // software keeps the threshold at 2 or 3 [RQ8]
  assign enough = (i_tx_pkt_cells >= {6'h00, thr_r}) // [RQ6]
                | i_tx_pkt_whole;                   // [RQ7]
  assign may_go = ~pause_act | i_tx_pkt_is_pause;   // [RQ4]

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r         <= ST_IDLE;
      o_tx_start   <= 1'b0;
      o_tx_sending <= 1'b0;
    end else if (i_ce) begin
      o_tx_start <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (i_tx_pkt_ready & enough & may_go) begin
            st_r         <= ST_SEND;
            o_tx_start   <= 1'b1;
            o_tx_sending <= 1'b1;
          end
        end
        ST_SEND: begin
          // pause never cuts a frame short
          if (i_tx_pkt_done) begin // [RQ5]
            st_r         <= ST_IDLE;
            o_tx_sending <= 1'b0;
          end
        end
        default: begin
          st_r         <= ST_IDLE;
          o_tx_sending <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output

  reg [`IRQ_BITS-1:0] ists_r;
  reg [`IRQ_BITS-1:0] imsk_r;
  reg                 pause_d_r;
  reg                 flow_d_r;
  wire [`IRQ_BITS-1:0] ev;
  reg [`IRQ_BITS-1:0] ists_nxt;

  // rx flow event is the rising edge of the registered flag
  assign ev[`IRQ_HOST_FAULT]  = i_rx_fault;
  assign ev[`IRQ_PAUSE_START] = pause_act & ~pause_d_r;
  assign ev[`IRQ_RX_FLOW]     = o_rx_flow_active & ~flow_d_r;

  always @* begin
    // events set over a simultaneous write-one clear
    if (wr_ists)
      ists_nxt = (ists_r & ~hwdata[`IRQ_BITS-1:0]) | ev;
    else
      ists_nxt = ists_r | ev;
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      ists_r    <= {`IRQ_BITS{1'b0}};
      imsk_r    <= {`IRQ_BITS{1'b0}};
      pause_d_r <= 1'b0;
      flow_d_r  <= 1'b0;
      o_irq     <= 1'b0;
    end else if (i_ce) begin
      pause_d_r <= pause_act;
      flow_d_r  <= o_rx_flow_active;
      ists_r <= ists_nxt;
      if (wr_imsk)
        imsk_r <= hwdata[`IRQ_BITS-1:0];
      o_irq <= |(ists_r & imsk_r);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux, registered into the data phase

  reg [31:0] rd_val;

  always @* begin
    rd_val = 32'h0000_0000;
    case (a_ofs)
      `OFS_STATUS: begin
        rd_val[`ST_TX_PAUSE] = o_tx_pause_active;
        rd_val[`ST_RX_FLOW]  = o_rx_flow_active;
        rd_val[`ST_RX_QOS]   = o_rx_qos_active;
        rd_val[`ST_FCH_HI:`ST_FCH_LO]     = fault_ch_r;
        rd_val[`ST_FCODE_HI:`ST_FCODE_LO] = fault_code_r;
      end
      `OFS_EMU_CTRL: begin
        rd_val[`EMU_SOFT] = o_emu_soft;
        rd_val[`EMU_FREE] = o_emu_free;
      end
      `OFS_FIFO_CTRL:
        rd_val[`THR_HI:`THR_LO] = thr_r;
      `OFS_BUILD:
        rd_val = {`BUILD_TX_CELLS,  // [RQ9]
                  `BUILD_RX_CELLS,  // [RQ10]
                  `BUILD_ADDR_KIND,
                  `BUILD_MAC_VALUE};
      `OFS_IRQ_STATUS:
        rd_val[`IRQ_BITS-1:0] = ists_r;
      `OFS_IRQ_MASK:
        rd_val[`IRQ_BITS-1:0] = imsk_r;
      // unmapped offsets read as zero
      default:
        rd_val = 32'h0000_0000; // [RQ14]
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n)
      hrdata <= 32'h0000_0000;
    else if (i_ce && rd_take)
      hrdata <= rd_val;
  end

endmodule

// *** test/tx_link_model.sv ***
// transmit line partner: answers each frame start with a done pulse
// assumes the start pulse lasts one cycle
`timescale 1ns/1ps
module tx_link_model (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_start,
  input  wire [3:0] i_len,
  output reg        o_done
);
  reg [3:0] cnt_r;
  reg       busy_r;
  // frame stays on the line i_len+1 cycles whatever the pause state
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (!i_rst_n) begin
      busy_r <= 1'b0;
    end else if (i_start) begin
      busy_r <= 1'b1;
      cnt_r  <= i_len;
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r <= 1'b0;
      o_done <= 1'b1;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule

// *** test/mac_flow_status_sva.sv ***
// flag and transmit gating relations of mac_flow_status
// assumes clock enable held high and threshold programmed 2 or 3
`timescale 1ns/1ps
module mac_flow_status_sva #(parameter NCH = 8, parameter CW = 8, parameter QW = 16) (
  input wire              i_clk,
  input wire              i_rst_n,
  input wire              i_rx_qos_enable,
  input wire [CW-1:0]     i_rx_qos_low_threshold,
  input wire [NCH*CW-1:0] i_rx_chan_free_buffers,
  input wire [NCH*CW-1:0] i_rx_chan_flow_threshold,
  input wire              i_pause_rx,
  input wire [QW-1:0]     i_pause_quanta,
  input wire              i_tx_pkt_ready,
  input wire              i_tx_pkt_is_pause,
  input wire [7:0]        i_tx_pkt_cells,
  input wire              i_tx_pkt_whole,
  input wire              i_tx_pkt_done,
  input wire              o_rx_qos_active,
  input wire              o_rx_flow_active,
  input wire              o_tx_pause_active,
  input wire              o_tx_start,
  input wire              o_tx_sending
);
  logic ql;
  logic fl;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  always_comb begin
    ql = 1'b0;
    fl = 1'b0;
    for (int n = 0; n < NCH; n++) begin
      ql |= i_rx_chan_free_buffers[n*CW+:CW] <= i_rx_qos_low_threshold;
      fl |= i_rx_chan_free_buffers[n*CW+:CW] <= i_rx_chan_flow_threshold[n*CW+:CW];
    end
  end
  AST_QOS: assert property ($past(i_rst_n) |-> o_rx_qos_active == $past(i_rx_qos_enable && ql))
    else $error("qos flag wrong");
  AST_FLOW: assert property ($past(i_rst_n) |-> o_rx_flow_active == $past(fl))
    else $error("flow flag wrong");
  AST_PSET: assert property (i_pause_rx && i_pause_quanta != 0 |-> ##2 o_tx_pause_active)
    else $error("pause flag not set");
  AST_PCLR: assert property (i_pause_rx && i_pause_quanta == 0 |-> ##2 !o_tx_pause_active)
    else $error("pause flag not cleared");
  AST_GATE: assert property (o_tx_start |-> !o_tx_pause_active || $past(i_tx_pkt_is_pause))
    else $error("start during pause");
  AST_START: assert property (o_tx_start |-> $past(i_tx_pkt_ready && (i_tx_pkt_cells >= 8'h02 || i_tx_pkt_whole)))
    else $error("start too early");
  AST_PULSE: assert property (o_tx_start |=> !o_tx_start)
    else $error("start not a pulse");
  AST_HOLD: assert property (o_tx_sending && !i_tx_pkt_done |=> o_tx_sending)
    else $error("frame aborted");
  AST_SEND: assert property (o_tx_start |-> o_tx_sending)
    else $error("start without sending");
endmodule
bind mac_flow_status mac_flow_status_sva #(.NCH(NCH), .CW(CW), .QW(QW)) u_sva (.i_clk, .i_rst_n,
  .i_rx_qos_enable, .i_rx_qos_low_threshold, .i_rx_chan_free_buffers, .i_rx_chan_flow_threshold,
  .i_pause_rx, .i_pause_quanta, .i_tx_pkt_ready, .i_tx_pkt_is_pause, .i_tx_pkt_cells, .i_tx_pkt_whole,
  .i_tx_pkt_done, .o_rx_qos_active, .o_rx_flow_active, .o_tx_pause_active, .o_tx_start, .o_tx_sending);

// *** test/mac_flow_status_tb.sv ***
// self-checking bench for mac_flow_status
// assumes a zero-wait ahb-lite slave and the transmit line partner
`timescale 1ns/1ps
`include "mac_flow_regs.vh"
module mac_flow_status_tb;
  logic        i_clk, i_rst_n, hsel, hwrite, i_rx_qos_enable, i_rx_fault, i_pause_rx;
  logic        i_tx_pkt_ready, i_tx_pkt_is_pause, i_tx_pkt_whole, i_tx_pkt_done, hreadyout, hresp;
  logic        o_rx_qos_active, o_rx_flow_active, o_tx_pause_active, o_tx_start;
  logic        o_tx_sending, o_emu_soft, o_emu_free, o_irq, ef, eq, fr;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize, i_rx_fault_channel;
  logic [3:0]  i_rx_fault_code, len;
  logic [7:0]  i_rx_qos_low_threshold, i_tx_pkt_cells, c;
  logic [15:0] i_pause_quanta;
  logic [63:0] i_rx_chan_free_buffers, i_rx_chan_flow_threshold;
  int          n_mismatch, check_count, k;
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h2, 32'h03030101, 32'h0, 32'h0, 32'h0};
  wire         hready = hreadyout;
  mac_flow_status #(.QCYC(4)) i_dut (.i_clk, .i_rst_n, .i_ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .i_rx_qos_enable, .i_rx_qos_low_threshold,
    .i_rx_chan_free_buffers, .i_rx_chan_flow_threshold, .i_rx_fault, .i_rx_fault_channel, .i_rx_fault_code,
    .i_pause_rx, .i_pause_quanta, .i_tx_pkt_ready, .i_tx_pkt_is_pause, .i_tx_pkt_cells, .i_tx_pkt_whole,
    .i_tx_pkt_done, .o_rx_qos_active, .o_rx_flow_active, .o_tx_pause_active, .o_tx_start, .o_tx_sending,
    .o_emu_soft, .o_emu_free, .o_irq);
  tx_link_model i_link (.i_clk, .i_rst_n, .i_start(o_tx_start), .i_len(len), .o_done(i_tx_pkt_done));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  ////////////////////////////////////////
  function logic anyle(logic [63:0] f, t);
    anyle = 1'b0;
    for (int n = 0; n < 8; n++) if (f[n*8+:8] <= t[n*8+:8]) anyle = 1'b1;
  endfunction
  task chk(string n, logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task bus(logic w, logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge i_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task rd(string n, logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    chk(n, e, r);
    chk("response", 32'h0, hresp);
  endtask
  task tx(logic [7:0] cl, logic w, p, e);
    i_tx_pkt_cells <= cl;
    i_tx_pkt_whole <= w;
    i_tx_pkt_is_pause <= p;
    i_tx_pkt_ready <= 1'b1;
    k = 0;
    do begin @(posedge i_clk); k++; end while (o_tx_start !== 1'b1 && k < 8);
    chk("start", e, o_tx_start);
    i_tx_pkt_ready <= 1'b0;
    @(posedge i_clk);
    k = 0;
    while (o_tx_sending === 1'b1 && k < 40) begin @(posedge i_clk); k++; end
  endtask
  task pz(logic [15:0] q);
    i_pause_quanta <= q;
    i_pause_rx <= 1'b1;
    @(posedge i_clk);
    i_pause_rx <= 1'b0;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #400000;
    n_mismatch++;
    final_report;
  end
  initial begin
    {hsel, hwrite, i_rx_qos_enable, i_rx_fault, i_pause_rx, i_tx_pkt_ready, i_tx_pkt_is_pause} = 7'h00;
    {haddr, hwdata, htrans, i_rx_fault_channel, i_rx_fault_code, i_pause_quanta} = 0;
    {i_tx_pkt_whole, i_rx_qos_low_threshold, i_tx_pkt_cells, i_rx_chan_flow_threshold} = 0;
    hsize = 3'h2;
    len = 4'h2;
    i_rx_chan_free_buffers = {8{8'hFF}};
    i_rst_n = 1'b0;
    k = $urandom(32'h50d6);
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    for (int a = 0; a < 7; a++) rd("reset value", a * 4, rv[a]);
    bus(1'b1, `OFS_EMU_CTRL, 32'hFFFFFFFF);
    rd("emulation", `OFS_EMU_CTRL, 32'h3);
    chk("emulation pins", 2'h3, {o_emu_soft, o_emu_free});
    bus(1'b1, `OFS_FIFO_CTRL, 32'hFFFFFFFF);
    rd("threshold", `OFS_FIFO_CTRL, 32'h3);
    tx(8'h02, 1'b0, 1'b0, 1'b0);
    tx(8'h03, 1'b0, 1'b0, 1'b1);
    bus(1'b1, `OFS_FIFO_CTRL, 32'h2);
    tx(8'h01, 1'b0, 1'b0, 1'b0);
    tx(8'h01, 1'b1, 1'b0, 1'b1);
    repeat (12) begin
      c = 8'h01 + $urandom % 3;
      len = $urandom % 8;
      eq = ($urandom % 2) != 0;
      tx(c, eq, 1'b0, c >= 8'h02 || eq);
    end
    fr = 1'b0;
    repeat (20) begin
      i_rx_chan_free_buffers <= {$urandom, $urandom} & {8{8'h07}};
      i_rx_chan_flow_threshold <= {$urandom, $urandom} & {8{8'h03}};
      i_rx_qos_low_threshold <= $urandom % 4;
      i_rx_qos_enable <= $urandom % 2;
      repeat (3) @(posedge i_clk);
      ef = anyle(i_rx_chan_free_buffers, i_rx_chan_flow_threshold);
      eq = i_rx_qos_enable & anyle(i_rx_chan_free_buffers, {8{i_rx_qos_low_threshold}});
      fr = fr | ef;
      chk("flow pin", ef, o_rx_flow_active);
      chk("qos pin", eq, o_rx_qos_active);
      rd("status flags", `OFS_STATUS, {eq, ef, 1'b0});
    end
    len = 4'h2;
    pz(16'h0008);
    tx(8'h02, 1'b0, 1'b1, 1'b1);
    tx(8'h02, 1'b0, 1'b0, 1'b0);
    chk("pause pin", 1'b1, o_tx_pause_active);
    pz(16'h0000);
    repeat (2) @(posedge i_clk);
    chk("pause cleared", 1'b0, o_tx_pause_active);
    tx(8'h02, 1'b0, 1'b0, 1'b1);
    len = 4'hC;
    i_tx_pkt_ready <= 1'b1;
    k = 0;
    do begin @(posedge i_clk); k++; end while (o_tx_start !== 1'b1 && k < 8);
    i_tx_pkt_ready <= 1'b0;
    pz(16'h0003);
    repeat (3) @(posedge i_clk);
    chk("sending kept", 2'h3, {o_tx_sending, o_tx_pause_active});
    while (o_tx_sending === 1'b1 && k < 40) begin @(posedge i_clk); k++; end
    pz(16'h0000);
    i_rx_chan_free_buffers <= {8{8'hFF}};
    i_rx_qos_enable <= 1'b0;
    repeat (2) @(posedge i_clk);
    rd("irq events", `OFS_IRQ_STATUS, {fr, 1'b1, 1'b0});
    bus(1'b1, `OFS_IRQ_STATUS, 32'h7);
    for (int a = 0; a < 2; a++) begin
      i_rx_fault <= 1'b1;
      i_rx_fault_channel <= a ? 3'h3 : 3'h7;
      i_rx_fault_code <= a ? 4'h2 : 4'h4;
      @(posedge i_clk);
      i_rx_fault <= 1'b0;
      repeat (2) @(posedge i_clk);
      rd("fault fields", `OFS_STATUS, a ? 32'h2300 : 32'h4700);
    end
    rd("channel cleared", `OFS_STATUS, 32'h2000);
    rd("irq status", `OFS_IRQ_STATUS, 32'h1);
    chk("irq masked", 1'b0, o_irq);
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge i_clk);
    chk("irq raised", 1'b1, o_irq);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge i_clk);
    chk("irq cleared", 1'b0, o_irq);
    final_report;
  end
endmodule
